/* File: include/ccl_pkg.sv */
/*
  Shared constants for the comparator control logic: register indices,
  field positions, reset values, input-select codes and the instruction
  cycle divide ratio.
  Assumes a 32-bit APB host; each register index is one word, byte address
  is four times the index.
*/
package ccl_pkg;
	localparam int          NUM_CMP       = 3;
	localparam int          APB_AW        = 16;
	// register indices; comparator n sits one stride below comparator n-1
	localparam logic [11:0] CMP1_BASE_IDX = 12'hED0;
	localparam logic [11:0] CMP_STRIDE    = 12'h004;
	localparam logic [11:0] CON0_OFS      = 12'h000;
	localparam logic [11:0] CON1_OFS      = 12'h001;
	localparam logic [11:0] NSEL_OFS      = 12'h002;
	localparam logic [11:0] PSEL_OFS      = 12'h003;
	localparam logic [11:0] OUT_IDX       = 12'hED4;
	localparam logic [11:0] FLAG_IDX      = 12'hED5;
	localparam logic [11:0] IEN_IDX       = 12'hED6;
	// field positions
	localparam int          CON0_EN_BIT   = 7;
	localparam int          CON0_OUT_BIT  = 6;
	localparam int          CON0_POL_BIT  = 4;
	localparam int          CON0_HYS_BIT  = 1;
	localparam int          CON0_SYNC_BIT = 0;
	localparam int          CON1_RISE_BIT = 1;
	localparam int          CON1_FALL_BIT = 0;
	localparam int          IEN_PERI_BIT  = 6;
	localparam int          IEN_GLOB_BIT  = 7;
	// reset values
	localparam logic [7:0]  CON0_RST      = 8'h00;
	localparam logic [7:0]  CON1_RST      = 8'h00;
	localparam logic [2:0]  SEL_RST       = 3'h0;
	localparam logic [7:0]  IEN_RST       = 8'h00;
	// input select codes
	localparam logic [2:0]  PSEL_NC_LO    = 3'h2;
	localparam logic [2:0]  PSEL_NC_HI    = 3'h4;
	localparam logic [2:0]  NSEL_NC       = 3'h5;
	// one instruction cycle in pclk cycles
	localparam int          INST_DIV      = 4;
endpackage

/* File: src/ccl_sync3.sv */
/*
  Three-flop synchroniser for a group of asynchronous levels, with a settled
  copy and one-cycle rise and fall pulses.
  Assumes inputs may change at any time relative to pclk.
*/
`timescale 1ns/1ps
module ccl_sync3 #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
		logic [W-1:0] r;
		logic [W-1:0] f;
	} ccl_sync_st_t;

	ccl_sync_st_t q;
	ccl_sync_st_t n;
	logic [W-1:0] chg;

	// a change counts only once stages two and three agree
	always_comb
	begin
		n    = q;
		n.s1 = async_in;
		n.s2 = q.s1;
		n.s3 = q.s2;
		chg  = ~(q.s2 ^ q.s3) & (q.s2 ^ q.lvl);
		n.lvl = q.lvl ^ chg;
		n.r  = chg & q.s2;
		n.f  = chg & ~q.s2;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= n;
	end

	assign level = q.lvl;
	assign rise  = q.r;
	assign fall  = q.f;
endmodule

/* File: src/ccl_cycle_div.sv */
/*
  Divider giving a one-cycle enable pulse once per instruction cycle.
  Assumes a free-running pclk.
*/
`timescale 1ns/1ps
module ccl_cycle_div #(
	parameter int DIV = 4
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} ccl_div_st_t;

	ccl_div_st_t q;
	ccl_div_st_t n;

	// wrap counter, pulse on the last count
	always_comb
	begin
		n      = q;
		n.tick = (q.cnt == LAST);
		n.cnt  = (q.cnt == LAST) ? '0 : CW'(q.cnt + 1'b1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= n;
	end

	assign tick = q.tick;
endmodule

/* File: src/ccl_top.sv */
/*
  Digital control for three analog comparators: APB registers, enable and
  polarity handling, instruction-cycle latching, Timer1-aligned output,
  edge flags, interrupt gating and trigger outputs to other peripherals.
  Assumes the analog cores report their raw result on cmp_above, and that
  the prescaled Timer1 clock arrives as an asynchronous level on t1_clk_in.
*/
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - raw result is high when noninverting input exceeds inverting input
// - power off disconnects both input selects and forces raw result zero
// - output equals raw result, or its complement when invert set
// - output readable in own control register and shared mirror register
// - internal output latched each instruction cycle; pin output not latched
// - hysteresis bit switches hysteresis on the comparator inputs
// - aligned mode captures output to timer and pin on Timer1 falling edge
// - capture uses the prescaled Timer1 clock
// - aligned output changes only on falling Timer1 edges
// - output offered as gate source to odd-numbered timers
// - alignment tied to Timer1 clock; other timers need same source
// - rising edge sets flag if rise enable; falling edge if fall enable
// - software clears the flag; a simultaneous edge leaves it set
// - edges seen on polarised output even while powered off
// - interrupt needs comparator, peripheral and global enables
// - positive select routes pin, DAC output or reference buffer
// - negative select routes pin, reference buffer or ground
// - rising output triggers ADC conversion when selected
// - rising output resets even-numbered timer when selected
// - active output with shutdown enable suspends waveform generator
// - works in sleep; aligned outputs stop if Timer1 runs on system clock
// - comparator interrupt wakes device when its enable set
// - positive codes: 0,1 pins, 2-4 open, 5 DAC, 6 ref, 7 ground
// - negative codes: 0-4 pins, 5 open, 6 ref, 7 ground
module ccl_top
	import ccl_pkg::*;
(
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic [ccl_pkg::APB_AW-1:0]      paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [31:0]                     pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic [ccl_pkg::NUM_CMP-1:0]     cmp_above,
	input  wire logic                            t1_clk_in,
	input  wire logic                            t1_from_sysclk,
	input  wire logic                            sleep_mode,
	input  wire logic [ccl_pkg::NUM_CMP-1:0]     adc_trigger_select,
	input  wire logic [ccl_pkg::NUM_CMP-1:0]     timer_external_reset_select,
	input  wire logic [ccl_pkg::NUM_CMP-1:0]     shutdown_source_enable,
	output logic      [ccl_pkg::NUM_CMP-1:0]     comparator_power_on_bit,
	output logic      [ccl_pkg::NUM_CMP-1:0]     input_hysteresis,
	output logic      [3*ccl_pkg::NUM_CMP-1:0]   positive_input_select,
	output logic      [3*ccl_pkg::NUM_CMP-1:0]   negative_input_select,
	output logic      [ccl_pkg::NUM_CMP-1:0]     pos_connect,
	output logic      [ccl_pkg::NUM_CMP-1:0]     neg_connect,
	output logic      [ccl_pkg::NUM_CMP-1:0]     comparator_result_bit,
	output logic      [ccl_pkg::NUM_CMP-1:0]     pin_out,
	output logic      [ccl_pkg::NUM_CMP-1:0]     timer_gate,
	output logic                                 adc_trigger,
	output logic                                 timer_reset,
	output logic                                 wg_shutdown,
	output logic      [ccl_pkg::NUM_CMP-1:0]     comparator_irq_flag,
	output logic                                 irq_out,
	output logic                                 wake_req
);
	import ccl_pkg::*;

	typedef struct packed {
		logic [NUM_CMP-1:0]      en;
		logic [NUM_CMP-1:0]      output_invert_field;
		logic [NUM_CMP-1:0]      hys;
		logic [NUM_CMP-1:0]      sync;
		logic [NUM_CMP-1:0]      rise_on;
		logic [NUM_CMP-1:0]      fall_on;
		logic [NUM_CMP-1:0][2:0] nsel;
		logic [NUM_CMP-1:0][2:0] psel;
		logic [NUM_CMP-1:0]      pos_conn;
		logic [NUM_CMP-1:0]      neg_conn;
		logic [NUM_CMP-1:0]      out_lat;
		logic [NUM_CMP-1:0]      sync_out;
		logic [NUM_CMP-1:0]      ext_out;
		logic [NUM_CMP-1:0]      rise_p;
		logic [NUM_CMP-1:0]      flag;
		logic [NUM_CMP-1:0]      ien;
		logic                    peripheral_irq_gate;
		logic                    global_irq_gate;
		logic                    irq;
		logic                    wake;
		logic                    adc_trig;
		logic                    tmr_rst;
		logic                    wg_shut;
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
	} ccl_top_st_t;

	ccl_top_st_t q;
	ccl_top_st_t n;

	logic [NUM_CMP-1:0] raw;
	logic               t1_fall;
	logic               inst_tick;
	logic [NUM_CMP-1:0] cur;
	logic [NUM_CMP-1:0] new_out;
	logic [NUM_CMP-1:0] fall_p;
	logic [NUM_CMP-1:0] set_f;
	logic [NUM_CMP-1:0] clr_f;
	logic [11:0]        idx;
	logic [11:0]        base;
	logic               wr_acc;
	logic               rd_hit;
	logic [7:0]         rd_byte;
	logic               sync_run;

	// analog results are asynchronous to pclk
	ccl_sync3 #(
		.W(NUM_CMP)
	) u_raw_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (cmp_above),
		.level    (raw),
		.rise     (),
		.fall     ()
	);

	// prescaled Timer1 clock sampled as a level; only its falling edge is used
	ccl_sync3 #(
		.W(1)
	) u_t1_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (t1_clk_in),
		.level    (),
		.rise     (),
		.fall     (t1_fall)
	);

	ccl_cycle_div #(
		.DIV(INST_DIV)
	) u_inst_div (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (inst_tick)
	);

	// next-state logic: register file, output path, flags, APB answer
	always_comb
	begin
		n       = q;
		idx     = paddr[13:2];
		wr_acc  = psel && penable && q.pready && pwrite && pstrb[0];
		rd_hit  = 1'b0;
		rd_byte = 8'h00;
		base    = 12'h000;
		clr_f   = '0;
		// timer on system clock halts in sleep, so aligned outputs freeze
		sync_run = !(sleep_mode && t1_from_sysclk);
		for (int i = 0; i < NUM_CMP; i++)
		begin
			base = 12'(CMP1_BASE_IDX - CMP_STRIDE * 12'(i));
			// powered-off core reads as 0 before polarity
			cur[i] = (q.en[i] & raw[i]) ^ q.output_invert_field[i];
			new_out[i] = inst_tick ? cur[i] : q.out_lat[i];
			if (idx == base + CON0_OFS)
			begin
				rd_hit  = 1'b1;
				rd_byte = 8'h00;
				rd_byte[CON0_EN_BIT]   = q.en[i];
				rd_byte[CON0_OUT_BIT]  = q.out_lat[i];
				rd_byte[CON0_POL_BIT]  = q.output_invert_field[i];
				rd_byte[CON0_HYS_BIT]  = q.hys[i];
				rd_byte[CON0_SYNC_BIT] = q.sync[i];
				if (wr_acc)
				begin
					n.en[i]   = pwdata[CON0_EN_BIT];
					n.output_invert_field[i]  = pwdata[CON0_POL_BIT];
					n.hys[i]  = pwdata[CON0_HYS_BIT];
					n.sync[i] = pwdata[CON0_SYNC_BIT];
				end
			end
			if (idx == base + CON1_OFS)
			begin
				rd_hit  = 1'b1;
				rd_byte = 8'h00;
				rd_byte[CON1_RISE_BIT] = q.rise_on[i];
				rd_byte[CON1_FALL_BIT] = q.fall_on[i];
				if (wr_acc)
				begin
					n.rise_on[i] = pwdata[CON1_RISE_BIT];
					n.fall_on[i] = pwdata[CON1_FALL_BIT];
				end
			end
			if (idx == base + NSEL_OFS)
			begin
				rd_hit  = 1'b1;
				rd_byte = {5'h00, q.nsel[i]};
				if (wr_acc)
					n.nsel[i] = pwdata[2:0];
			end
			if (idx == base + PSEL_OFS)
			begin
				rd_hit  = 1'b1;
				rd_byte = {5'h00, q.psel[i]};
				if (wr_acc)
					n.psel[i] = pwdata[2:0];
			end
			// open codes and power-off leave the input floating
			n.pos_conn[i] = n.en[i]
				&& !(n.psel[i] >= PSEL_NC_LO && n.psel[i] <= PSEL_NC_HI);
			n.neg_conn[i] = n.en[i] && (n.nsel[i] != NSEL_NC);
			// aligned capture on the prescaled Timer1 falling edge only
			if (t1_fall && sync_run)
				n.sync_out[i] = cur[i];
			// pin and gate follow the live value unless aligned mode is on
			n.ext_out[i] = q.sync[i] ? n.sync_out[i] : cur[i];
		end
		if (idx == OUT_IDX)
		begin
			rd_hit  = 1'b1;
			rd_byte = {5'h00, q.out_lat};
		end
		if (idx == FLAG_IDX)
		begin
			rd_hit  = 1'b1;
			rd_byte = {5'h00, q.flag};
			if (wr_acc)
				clr_f = pwdata[NUM_CMP-1:0];
		end
		if (idx == IEN_IDX)
		begin
			rd_hit  = 1'b1;
			rd_byte = {q.global_irq_gate, q.peripheral_irq_gate, 3'h0, q.ien};
			if (wr_acc)
			begin
				n.ien  = pwdata[NUM_CMP-1:0];
				n.peripheral_irq_gate = pwdata[IEN_PERI_BIT];
				n.global_irq_gate  = pwdata[IEN_GLOB_BIT];
			end
		end
		// edge pulses from this cycle's latch versus the previous one
		n.out_lat = new_out;
		n.rise_p  = new_out & ~q.out_lat;
		fall_p    = ~new_out & q.out_lat;
		set_f     = (n.rise_p & q.rise_on) | (fall_p & q.fall_on);
		// a set in the clearing cycle wins
		n.flag    = (q.flag & ~clr_f) | set_f;
		n.irq     = (|(n.flag & n.ien)) && n.peripheral_irq_gate && n.global_irq_gate;
		n.wake    = |(n.flag & n.ien);
		n.adc_trig = |(n.rise_p & adc_trigger_select);
		n.tmr_rst  = |(n.rise_p & timer_external_reset_select);
		// shutdown acts on the live value, no latch delay
		n.wg_shut  = |(cur & shutdown_source_enable);
		// answer one cycle after setup: data captured at setup
		n.pready  = psel && !penable;
		if (psel && !penable)
		begin
			n.prdata  = {24'h000000, rd_byte};
			n.pslverr = !rd_hit;
		end
		else
		begin
			n.prdata  = q.prdata;
			n.pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q         <= '0;
			q.en      <= {NUM_CMP{CON0_RST[CON0_EN_BIT]}};
			q.output_invert_field     <= {NUM_CMP{CON0_RST[CON0_POL_BIT]}};
			q.rise_on <= {NUM_CMP{CON1_RST[CON1_RISE_BIT]}};
			q.nsel    <= {NUM_CMP{SEL_RST}};
			q.psel    <= {NUM_CMP{SEL_RST}};
			q.peripheral_irq_gate    <= IEN_RST[IEN_PERI_BIT];
		end
		else
			q <= n;
	end

	// all outputs come straight from state flops
	assign prdata                  = q.prdata;
	assign pready                  = q.pready;
	assign pslverr                 = q.pslverr;
	assign comparator_power_on_bit = q.en;
	assign input_hysteresis        = q.hys;
	assign positive_input_select   = q.psel;
	assign negative_input_select   = q.nsel;
	assign pos_connect             = q.pos_conn;
	assign neg_connect             = q.neg_conn;
	assign comparator_result_bit   = q.out_lat;
	assign pin_out                 = q.ext_out;
	assign timer_gate              = q.ext_out;
	assign adc_trigger             = q.adc_trig;
	assign timer_reset             = q.tmr_rst;
	assign wg_shutdown             = q.wg_shut;
	assign comparator_irq_flag     = q.flag;
	assign irq_out                 = q.irq;
	assign wake_req                = q.wake;

	// per-channel checks on comparator 0; the other channels share the same code
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	off_forces_zero_a: assert property (
		(inst_tick && !q.en[0]) |=> (q.out_lat[0] == $past(q.output_invert_field[0])))
		else $error("powered-off comparator did not read as zero");

	polarity_latch_a: assert property (
		inst_tick |=> (q.out_lat[0] == ($past(q.en[0] & raw[0]) ^ $past(q.output_invert_field[0]))))
		else $error("latched output does not match polarised result");

	latch_hold_a: assert property (
		!inst_tick |=> $stable(q.out_lat))
		else $error("latched output changed outside instruction tick");

	mirror_read_a: assert property (
		(psel && !penable && idx == OUT_IDX) |=> (prdata[2:0] == $past(q.out_lat)))
		else $error("mirror register read does not show outputs");

	sync_fall_only_a: assert property (
		!t1_fall |=> $stable(q.sync_out))
		else $error("aligned output moved without Timer1 falling edge");

	set_wins_a: assert property (
		(set_f[0] && clr_f[0]) |=> (q.flag[0] ##1 1'b1))
		else $error("edge lost against software clear");

	irq_gates_a: assert property (
		irq_out |-> (q.peripheral_irq_gate && q.global_irq_gate && |(q.flag & q.ien)))
		else $error("interrupt raised without all enables");

	rise_pulse_a: assert property (
		q.rise_p[0] |-> (q.out_lat[0] && !$past(q.out_lat[0]) ##1 !q.rise_p[0]))
		else $error("rise pulse not tied to one latched transition");

	conn_off_a: assert property (
		!q.en[0] |-> (!q.pos_conn[0] && !q.neg_conn[0]))
		else $error("input connected while powered off");

	rise_c: cover property (q.rise_p[0] && q.flag[0]);
	fall_c: cover property ($fell(q.out_lat[0]) && q.fall_on[0]);
	sync_c: cover property (q.sync[0] && t1_fall && $changed(cur[0]));
	write_c: cover property (wr_acc && idx == IEN_IDX);
endmodule

/* File: verif/ccl_analog_model.sv */
/*
  Model of the analog side: three comparator cores and the prescaled
  Timer1 clock that the control block watches.
  Assumes the bench commands the wanted comparison and when Timer1 runs.
*/
`timescale 1ns/1ps
module ccl_analog_model #(
	parameter int T1_HALF = 5
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [2:0] power_on,
	input  wire logic [2:0] want_above,
	input  wire logic       t1_run,
	output logic      [2:0] cmp_above,
	output logic            t1_clk_in
);
	logic [2:0] noise_reg;
	int         t1_cnt;

	// unpowered cores have open inputs, so their result toggles every cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			noise_reg <= 3'h0;
			t1_cnt    <= 0;
			t1_clk_in <= 1'b0;
		end
		else
		begin
			noise_reg <= ~noise_reg;
			if (!t1_run)
			begin
				t1_cnt    <= 0;
				t1_clk_in <= 1'b0; // stands still low while stopped
			end
			else if (t1_cnt == T1_HALF - 1)
			begin
				t1_cnt    <= 0;
				t1_clk_in <= ~t1_clk_in; // already past the prescaler
			end
			else
				t1_cnt <= t1_cnt + 1;
		end
	end

	// high when the noninverting input is above the inverting one
	assign cmp_above = (power_on & want_above) | (~power_on & noise_reg);
endmodule

/* File: verif/test_comparator_control_logic.sv */
/*
  Self-checking bench for the comparator control block: registers over
  APB, polarity, edge flags, input routing, triggers and aligned output.
  Assumes ccl_analog_model stands on the far side of the comparator pins.
*/
`timescale 1ns/1ps
module test_comparator_control_logic;
	import ccl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic [3:0]  pstrb;
	logic [2:0]  want, cmp_above, adc_sel, rst_sel, sd_en, pwr, hys, pcon, ncon;
	logic [2:0]  res, pin, gate, flag;
	logic [8:0]  pcode, ncode;
	logic        t1_run, t1_clk, t1_sys, sleep, adc_trig, tmr_rst, wg_sd, irq, wake, err_q;
	int          fail_count, samples_checked, cycles, adc_cnt, rst_cnt;

	ccl_top ccl_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_above(cmp_above),
		.t1_clk_in(t1_clk), .t1_from_sysclk(t1_sys), .sleep_mode(sleep),
		.adc_trigger_select(adc_sel), .timer_external_reset_select(rst_sel),
		.shutdown_source_enable(sd_en), .comparator_power_on_bit(pwr),
		.input_hysteresis(hys), .positive_input_select(pcode),
		.negative_input_select(ncode), .pos_connect(pcon), .neg_connect(ncon),
		.comparator_result_bit(res), .pin_out(pin), .timer_gate(gate),
		.adc_trigger(adc_trig), .timer_reset(tmr_rst), .wg_shutdown(wg_sd),
		.comparator_irq_flag(flag), .irq_out(irq), .wake_req(wake));
	ccl_analog_model ccl_analog_model_i (.pclk(pclk), .presetn(presetn), .power_on(pwr),
		.want_above(want), .t1_run(t1_run), .cmp_above(cmp_above), .t1_clk_in(t1_clk));

	// clock, and a cycle ceiling against hangs
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		adc_cnt += (adc_trig === 1'b1);
		rst_cnt += (tmr_rst === 1'b1);
		if (cycles == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic logic [11:0] ci(input int c, input logic [11:0] o);
		return CMP1_BASE_IDX - CMP_STRIDE * 12'(c) + o;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one APB transfer after an idle edge, so a second call never drives psel
	// twice in one time step; data and error taken where pready is seen high
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd_q    = prdata;
		err_q   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// sync, instruction tick and register stage: 4 + 4 + 1, with margin
	task automatic settle();
		cyc(12);
	endtask

	task automatic t_regs();
		apb(0, ci(0, CON0_OFS), 8'h00);
		check(rd_q, 32'(CON0_RST));
		apb(1, ci(0, CON0_OFS), 8'h40);
		apb(0, ci(0, CON0_OFS), 8'h00);
		check(rd_q, 32'h0);
		apb(0, 12'h001, 8'h00);
		check(32'(err_q), 32'h1);
		// a write without its byte strobe must leave the core powered off
		pstrb <= 4'h0;
		apb(1, ci(0, CON0_OFS), 8'h80);
		pstrb <= 4'hF;
		apb(0, ci(0, CON0_OFS), 8'h00);
		check(rd_q, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_pol();
		want <= 3'b111;
		for (int c = 0; c < 3; c++)
		begin
			apb(1, ci(c, CON0_OFS), 8'h80);
			settle();
			check(32'(pwr[c]), 32'h1);
			check(32'(res[c]), 32'h1);
			check(32'(pin[c]), 32'h1);
			apb(0, ci(c, CON0_OFS), 8'h00);
			check(rd_q, 32'hC0);
			apb(0, OUT_IDX, 8'h00);
			check(32'(rd_q[c]), 32'h1);
			apb(1, ci(c, CON0_OFS), 8'h90);
			settle();
			check(32'(res[c]), 32'h0);
			apb(1, ci(c, CON0_OFS), 8'h10);
			settle();
			check(32'(res[c]), 32'h1);
			apb(1, ci(c, CON0_OFS), 8'h00);
			settle();
			check(32'(res[c]), 32'h0);
			check(32'(pwr[c]), 32'h0);
		end
		want <= 3'b000;
		$display("test polarity done");
	endtask

	task automatic t_irq();
		apb(1, IEN_IDX, 8'h01);
		apb(1, ci(0, CON1_OFS), 8'h02);
		want <= 3'b001;
		apb(1, ci(0, CON0_OFS), 8'h80);
		settle();
		check(32'(flag[0]), 32'h1);
		check(32'(irq), 32'h0);
		check(32'(wake), 32'h1);
		apb(1, IEN_IDX, 8'hC1);
		cyc(2);
		check(32'(irq), 32'h1);
		apb(1, FLAG_IDX, 8'h01);
		cyc(2);
		check(32'(flag[0]), 32'h0);
		apb(1, ci(0, CON0_OFS), 8'h00);
		settle();
		check(32'(flag[0]), 32'h0);
		// powered off: only polarity changes move the output now
		apb(1, ci(0, CON1_OFS), 8'h01);
		apb(1, ci(0, CON0_OFS), 8'h10);
		settle();
		check(32'(flag[0]), 32'h0);
		apb(1, ci(0, CON0_OFS), 8'h00);
		settle();
		check(32'(flag[0]), 32'h1);
		// find the tick phase from a latched change, then land a clear on the
		// very edge that latches a falling polarity flip
		apb(1, FLAG_IDX, 8'h01);
		apb(1, ci(0, CON0_OFS), 8'h10);
		while (res[0] !== 1'b1)
			@(posedge pclk);
		apb(1, ci(0, CON0_OFS), 8'h00);
		cyc(1);
		apb(1, FLAG_IDX, 8'h01);
		cyc(2);
		check(32'(flag[0]), 32'h1);
		apb(1, FLAG_IDX, 8'h07);
		apb(1, IEN_IDX, 8'h00);
		want <= 3'b000;
		$display("test interrupt done");
	endtask

	task automatic t_sel();
		apb(1, ci(1, CON0_OFS), 8'h82);
		for (int k = 0; k < 8; k++)
		begin
			apb(1, ci(1, PSEL_OFS), 8'(k));
			apb(1, ci(1, NSEL_OFS), 8'(k));
			cyc(2);
			check(32'(pcode[5:3]), 32'(k));
			check(32'(ncode[5:3]), 32'(k));
			check(32'(pcon[1]), 32'(k < 2 || k > 4));
			check(32'(ncon[1]), 32'(k != 5));
			check(32'(hys[1]), 32'h1);
		end
		apb(1, ci(1, CON0_OFS), 8'h00);
		cyc(2);
		check(32'({pcon[1], ncon[1]}), 32'h0);
		check(32'(hys[1]), 32'h0);
		$display("test select done");
	endtask

	task automatic t_trig();
		adc_sel <= 3'b100;
		rst_sel <= 3'b100;
		sd_en   <= 3'b100;
		apb(1, ci(2, CON0_OFS), 8'h80);
		settle();
		adc_cnt = 0;
		rst_cnt = 0;
		want <= 3'b100;
		settle();
		check(32'(adc_cnt), 32'h1);
		check(32'(rst_cnt), 32'h1);
		check(32'(wg_sd), 32'h1);
		check(32'(gate[2]), 32'h1);
		sd_en <= 3'b000;
		cyc(3);
		check(32'(wg_sd), 32'h0);
		want <= 3'b000;
		apb(1, ci(2, CON0_OFS), 8'h00);
		$display("test triggers done");
	endtask

	task automatic t_sync();
		t1_run <= 1'b1;
		apb(1, ci(0, CON0_OFS), 8'h81);
		cyc(40);
		t1_run <= 1'b0;
		// stopping may drop the timer clock once; let that edge pass first
		cyc(12);
		want   <= 3'b001;
		settle();
		check(32'(res[0]), 32'h1);
		check(32'({pin[0], gate[0]}), 32'h0);
		t1_run <= 1'b1;
		cyc(30);
		check(32'({pin[0], gate[0]}), 32'h3);
		t1_sys <= 1'b1;
		sleep  <= 1'b1;
		want   <= 3'b000;
		cyc(40);
		check(32'(pin[0]), 32'h1);
		check(32'(res[0]), 32'h0);
		sleep <= 1'b0;
		cyc(40);
		check(32'(pin[0]), 32'h0);
		t1_run <= 1'b0;
		t1_sys <= 1'b0;
		$display("test aligned output done");
	endtask

	// reset, then every scenario in turn
	initial
	begin
		{presetn, psel, penable, pwrite, t1_run, t1_sys, sleep} = 7'h0;
		{paddr, pwdata, want, adc_sel, rst_sel, sd_en} = '0;
		pstrb = 4'hF;
		{fail_count, samples_checked, cycles, adc_cnt, rst_cnt} = '0;
		cyc(6);
		presetn <= 1'b1;
		cyc(6);
		t_regs();
		t_pol();
		t_irq();
		t_sel();
		t_trig();
		t_sync();
		stop_test();
	end
endmodule
